// File: hw/ctm_compact_timer.sv
// compact 10-bit timer: counter, two comparators, output pin pair, apb slave
// assumes timer clock sources arrive as one-cycle enables on clk_i
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module ctm_compact_timer
    import ctm_pkg::*;
#(
    parameter int COUNT_WIDTH = 10
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // timer clock sources as enables
    input  wire logic        high_clock_tick_i,
    input  wire logic        sub_clock_tick_i,
    // interrupt requests and pins
    output logic             match_a_irq_o,
    output logic             match_p_irq_o,
    output logic             timer_out_true_o,
    output logic             timer_out_inverted_o
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]             timer_control_zero;
    logic [7:0]             timer_control_one;
    logic [COUNT_WIDTH-1:0] compare_a_value;
    logic [COUNT_WIDTH-1:0] count;
    logic [7:0]             hold_buffer;
    logic                   run_q;
    logic                   out_level;
    logic [5:0]             sys_div;
    logic [5:0]             high_div;

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    wire logic       counter_pause        = timer_control_zero[CTM_C0_PAUSE_BIT];
    wire logic [2:0] counter_clock_select = timer_control_zero[CTM_C0_CLKSEL_LSB +: 3];
    wire logic       timer_run_enable     = timer_control_zero[CTM_C0_RUN_BIT];
    wire logic [2:0] period_compare_value = timer_control_zero[CTM_C0_PERIOD_LSB +: 3];
    wire ctm_mode_t  operating_mode_select = ctm_mode_t'(timer_control_one[CTM_C1_MODE_LSB +: 2]);
    wire logic [1:0] pin_function         = timer_control_one[CTM_C1_PINFN_LSB +: 2];
    wire logic       init_level           = timer_control_one[CTM_C1_INIT_BIT];
    wire logic       polarity_invert      = timer_control_one[CTM_C1_POL_BIT];
    wire logic       duty_on_period_p     = timer_control_one[CTM_C1_DUPLEX_BIT];
    wire logic       clear_on_a           = timer_control_one[CTM_C1_CLRSEL_BIT];

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire logic access_phase = psel_i && penable_i;
    wire logic wr_en        = access_phase && pwrite_i;
    wire logic rd_en        = access_phase && !pwrite_i;
    wire logic hit_c0       = paddr_i == CTM_ADDR_CONTROL_ZERO;
    wire logic hit_c1       = paddr_i == CTM_ADDR_CONTROL_ONE;
    wire logic hit_dl       = paddr_i == CTM_ADDR_COUNT_LOW;
    wire logic hit_dh       = paddr_i == CTM_ADDR_COUNT_HIGH;
    wire logic hit_al       = paddr_i == CTM_ADDR_CMPA_LOW;
    wire logic hit_ah       = paddr_i == CTM_ADDR_CMPA_HIGH;
    wire logic mapped       = hit_c0 | hit_c1 | hit_dl | hit_dh | hit_al | hit_ah;

    assign pready_o  = 1'b1;
    assign pslverr_o = access_phase && !mapped;

    // ------------------------------------------------------------------
    // timer clock enable
    // ------------------------------------------------------------------
    // prescalers free-run so a source switch never waits a full divide
    wire logic sys_tick  = sys_div == CTM_DIV_SYS;
    wire logic high_16   = high_clock_tick_i && (high_div[3:0] == CTM_DIV_HIGH_16[3:0]);
    wire logic high_64   = high_clock_tick_i && (high_div == CTM_DIV_HIGH_64);
    logic timer_tick;
    always_comb begin
        case (counter_clock_select)
            3'h0:    timer_tick = sys_tick;
            3'h1:    timer_tick = 1'b1;
            3'h2:    timer_tick = high_16;
            3'h3:    timer_tick = high_64;
            3'h4,
            3'h5:    timer_tick = sub_clock_tick_i;
            default: timer_tick = 1'b0; // reserved codes stop the counter
        endcase
    end

    // ------------------------------------------------------------------
    // comparators and clear
    // ------------------------------------------------------------------
    wire logic run_rise  = timer_run_enable && !run_q;
    wire logic counting  = timer_run_enable && !counter_pause && timer_tick;
    wire logic match_a   = counting && (count == compare_a_value);
    wire logic match_p   = counting && (count[COUNT_WIDTH-1 -: 3] == period_compare_value) &&
                           (period_compare_value != 3'h0);
    wire logic overflow  = counting && (&count);
    // zero period compares as overflow: 1024 clocks
    wire logic event_p   = match_p || (overflow && period_compare_value == 3'h0);
    wire logic pwm_mode  = operating_mode_select == CTM_MODE_PWM;
    // pwm uses the period comparator named by the duplex bit
    wire logic clear_sel = pwm_mode ? (duty_on_period_p ? match_a : event_p)
                                    : (clear_on_a ? match_a : event_p);
    wire logic clear_cnt = clear_sel || overflow;
    wire logic duty_hit  = duty_on_period_p ? event_p : match_a;

    // ------------------------------------------------------------------
    // output pin logic
    // ------------------------------------------------------------------
    logic next_out_level;
    always_comb begin
        next_out_level = out_level;
        if (run_rise) begin
            next_out_level = pwm_mode ? !init_level : init_level;
        end else begin
            case (operating_mode_select)
                CTM_MODE_COMPARE: begin
                    if (match_a) begin
                        case (pin_function)
                            2'h1:    next_out_level = 1'b0;
                            2'h2:    next_out_level = 1'b1;
                            2'h3:    next_out_level = !out_level;
                            default: next_out_level = out_level;
                        endcase
                    end
                end
                CTM_MODE_PWM: begin
                    case (pin_function)
                        2'h0:    next_out_level = !init_level;
                        2'h1:    next_out_level = init_level;
                        2'h2: begin
                            if (clear_cnt) begin
                                next_out_level = init_level;
                            end else if (duty_hit) begin
                                next_out_level = !init_level;
                            end
                        end
                        default: next_out_level = out_level;
                    endcase
                end
                default: next_out_level = out_level;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // high byte of a counter-wide pair, spare bits read as zero
    function automatic logic [7:0] high_byte(input logic [COUNT_WIDTH-1:0] value);
        return {6'h00, value[COUNT_WIDTH-1 -: 2]};
    endfunction

    logic [7:0] read_byte;
    always_comb begin
        case (1'b1)
            hit_c0:  read_byte = timer_control_zero;
            hit_c1:  read_byte = timer_control_one;
            hit_dl,
            hit_al:  read_byte = hold_buffer;
            hit_dh:  read_byte = high_byte(count);
            hit_ah:  read_byte = high_byte(compare_a_value);
            default: read_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // next-state values
    // ------------------------------------------------------------------
    wire logic [5:0]             next_sys_div      = sys_tick ? 6'h00 : 6'(sys_div + 6'h01);
    wire logic [5:0]             next_high_div     = high_clock_tick_i ? 6'(high_div + 6'h01) : high_div;
    wire logic [7:0]             next_control_zero = (wr_en && hit_c0) ? pwdata_i[7:0] : timer_control_zero;
    wire logic [7:0]             next_control_one  = (wr_en && hit_c1) ? pwdata_i[7:0] : timer_control_one;

    // software keeps the access order; a wrong order reads a stale buffer
    wire logic [7:0]             next_hold_buffer  =
        (wr_en && hit_al) ? pwdata_i[7:0] :
        (wr_en && hit_ah) ? hold_buffer :
        (rd_en && hit_dh) ? count[7:0] :
        (rd_en && hit_ah) ? compare_a_value[7:0] :
                            hold_buffer;

    // high write and buffer transfer land in one edge
    wire logic [COUNT_WIDTH-1:0] next_compare_a    =
        (wr_en && hit_ah) ? COUNT_WIDTH'({pwdata_i[1:0], hold_buffer}) :
                            compare_a_value;

    // run rising wins over every other count change
    wire logic [COUNT_WIDTH-1:0] next_count        =
        run_rise  ? '0 :
        clear_cnt ? '0 :
        counting  ? COUNT_WIDTH'(count + 1'b1) :
                    count;

    wire logic                   next_pin_level    = next_out_level ^ polarity_invert;
    wire logic [31:0]            next_prdata       = {24'h00_0000, read_byte};

    // ------------------------------------------------------------------
    // prescalers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_div <= 6'h00;
        end else begin
            sys_div <= next_sys_div;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_div <= 6'h00;
        end else begin
            high_div <= next_high_div;
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_control_zero <= CTM_CONTROL_RESET;
        end else begin
            timer_control_zero <= next_control_zero;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_control_one <= CTM_CONTROL_RESET;
        end else begin
            timer_control_one <= next_control_one;
        end
    end

    // ------------------------------------------------------------------
    // shared buffer and compare a
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_buffer <= 8'h00;
        end else begin
            hold_buffer <= next_hold_buffer;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            compare_a_value <= '0;
        end else begin
            compare_a_value <= next_compare_a;
        end
    end

    // ------------------------------------------------------------------
    // counter and run edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_q <= 1'b0;
        end else begin
            run_q <= timer_run_enable;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_level <= 1'b0;
        end else begin
            out_level <= next_out_level;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            match_a_irq_o <= 1'b0;
        end else begin
            match_a_irq_o <= match_a;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            match_p_irq_o <= 1'b0;
        end else begin
            match_p_irq_o <= event_p;
        end
    end

    // both pins share one source so they never disagree
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_out_true_o <= 1'b0;
        end else begin
            timer_out_true_o <= next_pin_level;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            timer_out_inverted_o <= 1'b1;
        end else begin
            timer_out_inverted_o <= !next_pin_level;
        end
    end

    // read data follows the setup-phase address, ready in the access phase
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else begin
            prdata_o <= next_prdata;
        end
    end
endmodule

// File: hw/ctm_pkg.sv
// package for the compact timer: register map, field positions, modes
// assumes a 32-bit apb master and one 40 mhz clock
package ctm_pkg;
    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] CTM_ADDR_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] CTM_ADDR_CONTROL_ONE  = 8'h04;
    localparam logic [7:0] CTM_ADDR_COUNT_LOW    = 8'h08;
    localparam logic [7:0] CTM_ADDR_COUNT_HIGH   = 8'h0C;
    localparam logic [7:0] CTM_ADDR_CMPA_LOW     = 8'h10;
    localparam logic [7:0] CTM_ADDR_CMPA_HIGH    = 8'h14;

    // ------------------------------------------------------------------
    // control zero fields
    // ------------------------------------------------------------------
    localparam int CTM_C0_PAUSE_BIT  = 7;
    localparam int CTM_C0_CLKSEL_LSB = 4;
    localparam int CTM_C0_RUN_BIT    = 3;
    localparam int CTM_C0_PERIOD_LSB = 0;

    // ------------------------------------------------------------------
    // control one fields
    // ------------------------------------------------------------------
    localparam int CTM_C1_MODE_LSB   = 6;
    localparam int CTM_C1_PINFN_LSB  = 4;
    localparam int CTM_C1_INIT_BIT   = 3;
    localparam int CTM_C1_POL_BIT    = 2;
    localparam int CTM_C1_DUPLEX_BIT = 1;
    localparam int CTM_C1_CLRSEL_BIT = 0;

    // ------------------------------------------------------------------
    // reset values and prescaler lengths
    // ------------------------------------------------------------------
    localparam logic [7:0] CTM_CONTROL_RESET = 8'h00;
    localparam logic [5:0] CTM_DIV_SYS       = 6'h03;
    localparam logic [5:0] CTM_DIV_HIGH_16   = 6'h0F;
    localparam logic [5:0] CTM_DIV_HIGH_64   = 6'h3F;

    typedef enum logic [1:0] {
        CTM_MODE_COMPARE = 2'b00,
        CTM_MODE_UNDEF   = 2'b01,
        CTM_MODE_PWM     = 2'b10,
        CTM_MODE_TIMER   = 2'b11
    } ctm_mode_t;
endpackage

// File: dv/ctm_monitor.sv
// checker for the compact timer apb port and output pins
// assumes binding onto ctm_compact_timer, single clock domain
`timescale 1ns/10ps
module ctm_monitor
    import ctm_pkg::*;
#(
    parameter int COUNT_WIDTH = 10
) (
    // clock, reset and apb
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // events and pins
    input wire logic        match_a_irq_o,
    input wire logic        match_p_irq_o,
    input wire logic        timer_out_true_o,
    input wire logic        timer_out_inverted_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    wire  acc    = psel_i && penable_i;
    wire  mapped = (paddr_i <= CTM_ADDR_CMPA_HIGH) && (paddr_i[1:0] == 2'b00);
    logic run_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            run_q <= 1'b0;
        else if (acc && pwrite_i && paddr_i == CTM_ADDR_CONTROL_ZERO)
            run_q <= pwdata_i[CTM_C0_RUN_BIT];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    pin_pair_a: assert property (timer_out_inverted_o == !timer_out_true_o)
        else $error("output pins not complementary");
    ready_high_a: assert property (pready_o)
        else $error("slave inserted a wait state");
    slverr_map_a: assert property (acc |-> pslverr_o == !mapped)
        else $error("error response does not follow address map");
    slverr_phase_a: assert property (!penable_i |-> !pslverr_o)
        else $error("error response outside access phase");
    upper_zero_a: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h000000)
        else $error("read data above byte lane not zero");
    unmapped_zero_a: assert property (acc && !pwrite_i && !mapped |-> prdata_o == 32'h00000000)
        else $error("unmapped read not zero");
    count_high_a: assert property (acc && !pwrite_i && paddr_i == CTM_ADDR_COUNT_HIGH |-> prdata_o[7:2] == 6'h00)
        else $error("counter high byte spare bits set");
    buffer_echo_a: assert property (
        acc && pwrite_i && paddr_i == CTM_ADDR_CMPA_LOW ##3 acc && !pwrite_i && paddr_i == CTM_ADDR_CMPA_LOW
        |-> prdata_o[7:0] == $past(pwdata_i[7:0], 3)) else $error("low read did not return buffer");
    stop_quiet_a: assert property (!run_q && !$past(run_q) && !$past(run_q, 2) |-> !match_a_irq_o && !match_p_irq_o)
        else $error("match event while timer off");
endmodule

bind ctm_compact_timer ctm_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) u_monitor (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .match_a_irq_o(match_a_irq_o), .match_p_irq_o(match_p_irq_o), .timer_out_true_o(timer_out_true_o),
    .timer_out_inverted_o(timer_out_inverted_o)
);

// File: dv/ctm_compact_timer_bench.sv
// self-checking bench for the compact timer
// assumes ctm_pkg and the design are compiled first
`timescale 1ns/10ps
module ctm_compact_timer_bench;
    import ctm_pkg::*;
    logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, high_clock_tick_i, sub_clock_tick_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, match_a_irq_o, match_p_irq_o, timer_out_true_o, timer_out_inverted_o, err;
    int          failures, cmp_count;
    ctm_compact_timer uut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .high_clock_tick_i(high_clock_tick_i), .sub_clock_tick_i(sub_clock_tick_i),
        .match_a_irq_o(match_a_irq_o), .match_p_irq_o(match_p_irq_o), .timer_out_true_o(timer_out_true_o),
        .timer_out_inverted_o(timer_out_inverted_o));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // sub clock ticks every other cycle so its division is visible
    always @(posedge clk_i) sub_clock_tick_i <= ~sub_clock_tick_i;
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task conclude;
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            failures++;
            conclude();
        end
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask
    task read_count(output logic [31:0] v);
        logic [31:0] h;
        apb(1'b0, CTM_ADDR_COUNT_HIGH, 32'h0);
        h = rd;
        apb(1'b0, CTM_ADDR_COUNT_LOW, 32'h0);
        v = {h[23:0], rd[7:0]};
    endtask
    // cycles between two successive match events of one comparator
    task gap(input logic p, output int n);
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while ((p ? match_p_irq_o : match_a_irq_o) !== 1'b1 && k < 6000);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((p ? match_p_irq_o : match_a_irq_o) !== 1'b1 && n < 6000);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("pin pair", 32'h1, {30'h0, timer_out_true_o, timer_out_inverted_o});
    endtask
    task t_buffer;
        apb(1'b1, CTM_ADDR_CMPA_LOW, 32'h55);
        apb(1'b1, CTM_ADDR_CMPA_HIGH, 32'h02);
        apb(1'b0, CTM_ADDR_CMPA_HIGH, 32'h0);
        chk("cmpa high", 32'h02, rd);
        apb(1'b0, CTM_ADDR_CMPA_LOW, 32'h0);
        chk("cmpa low", 32'h55, rd);
        apb(1'b1, CTM_ADDR_CMPA_LOW, 32'hAA);
        apb(1'b0, CTM_ADDR_CMPA_HIGH, 32'h0);
        apb(1'b0, CTM_ADDR_CMPA_LOW, 32'h0);
        chk("cmpa kept", 32'h55, rd);
        apb(1'b1, CTM_ADDR_CMPA_LOW, 32'h3C);
        apb(1'b0, CTM_ADDR_CMPA_LOW, 32'h0);
        chk("buffer echo", 32'h3C, rd);
    endtask
    task t_clock;
        int   divs [6] = '{4, 1, 16, 64, 2, 2};
        int   n;
        logic o1;
        apb(1'b1, CTM_ADDR_CMPA_LOW, 32'h0A);
        apb(1'b1, CTM_ADDR_CMPA_HIGH, 32'h00);
        apb(1'b1, CTM_ADDR_CONTROL_ONE, 32'h31);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h00);
            apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'(i * 16 + 8));
            gap(1'b0, n);
            chk("match a period", (i < 6) ? 32'(11 * divs[i]) : 32'd6000, 32'(n));
            if (i < 6) begin
                repeat (3) @(posedge clk_i);
                o1 = timer_out_true_o;
                n = 0;
                do begin
                    @(posedge clk_i);
                    n++;
                end while (match_a_irq_o !== 1'b1 && n < 6000);
                repeat (3) @(posedge clk_i);
                chk("toggle", {31'h0, !o1}, {31'h0, timer_out_true_o});
            end
        end
    endtask
    task t_setclr;
        int n;
        for (int f = 1; f < 3; f++) begin
            apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h00);
            apb(1'b1, CTM_ADDR_CONTROL_ONE, 32'(1 + f * 16 + (f == 1) * 8));
            apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h18);
            repeat (2) @(posedge clk_i);
            chk("initial level", 32'(f == 1), {31'h0, timer_out_true_o});
            gap(1'b0, n);
            repeat (3) @(posedge clk_i);
            chk("match level", 32'(f == 2), {31'h0, timer_out_true_o});
        end
    endtask
    task t_wrap;
        int          n;
        logic [31:0] v1, v2;
        apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h00);
        apb(1'b1, CTM_ADDR_CONTROL_ONE, 32'hC0);
        apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h18);
        gap(1'b1, n);
        chk("overflow period", 32'd1024, 32'(n));
        apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h98);
        read_count(v1);
        repeat (40) @(posedge clk_i);
        apb(1'b1, CTM_ADDR_COUNT_LOW, 32'hFF);
        read_count(v2);
        chk("paused count", v1, v2);
        apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h18);
        read_count(v2);
        chk("resumed", 32'h1, 32'(v2 != v1));
        apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h00);
        apb(1'b1, CTM_ADDR_CONTROL_ZERO, 32'h08);
        read_count(v1);
        chk("restart count", 32'h1, 32'(v1 < 16));
    endtask
    initial begin
        failures = 0;
        cmp_count = 0;
        {reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {high_clock_tick_i, sub_clock_tick_i} = 2'b10;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_buffer();
        t_clock();
        t_setclr();
        t_wrap();
        conclude();
    end
endmodule
